//--- fss_consts.svh
`ifndef FSS_CONSTS_SVH
`define FSS_CONSTS_SVH

// bit positions inside the lock and fail status byte
`define FSS_POS_SCHEME 7
`define FSS_POS_ERASE_FAIL 6
`define FSS_POS_PROG_FAIL 5
`define FSS_POS_RSVD 4
`define FSS_POS_ERASE_PAUSED 3
`define FSS_POS_PROG_PAUSED 2
`define FSS_POS_LOCKDOWN 1
`define FSS_POS_FACTORY 0

// reset values of the volatile bits and of the reserved bit
`define FSS_RST_VOLATILE 1'b0
`define FSS_RST_RSVD 1'b0
`define FSS_RST_BYTE 8'h00

// opcode values, arbitrary defaults
`define FSS_OPC_READ_LOCK 8'h3c
`define FSS_OPC_WRITE_LOCK 8'h5a
`define FSS_OPC_WRITE_UNLOCK 8'h16
`define FSS_OPC_PROTECT_SEL 8'h69

// clocks in one command phase
`define FSS_SPI_CMD_CLKS 4'h8
`define FSS_QUAD_CMD_CLKS 4'h2
`define FSS_CNT_MAX 4'hf

// driver enables while the register byte is shifted out
`define FSS_OE_SPI 4'h2
`define FSS_OE_QUAD 4'hf

`endif

//--- fss_host_model.sv
`timescale 1ns/1ps
`default_nettype none

module fss_host_model (
    output logic sclk_o,
    output logic cs_n_o,
    output logic [3:0] sio_o,
    input wire logic [3:0] sio_i
);
    initial begin
        sclk_o = 1'h0;
        cs_n_o = 1'h1;
        sio_o = 4'h0;
    end

    // clock stands still outside frames; reads sampled before each rise
    task automatic frame(input logic [7:0] op, input logic quad,
            input int edges, input int units, output logic [15:0] rd);
        logic [15:0] cmd;
        cmd = {op, 8'h00};
        rd = 16'h0000;
        #7 cs_n_o = 1'h0;
        for (int i = 0; i < edges + units; i++) begin
            if (i < edges) begin
                // upper lines carry noise in single mode
                sio_o = quad ? cmd[15:12] : {~sio_o[3:1], cmd[15]};
                cmd = quad ? cmd << 4 : cmd << 1;
            end
            #16;
            if (i >= edges)
                rd = quad ? {rd[11:0], sio_i} : {rd[14:0], sio_i[1]};
            sclk_o = 1'h1;
            #16 sclk_o = 1'h0;
        end
        cs_n_o = 1'h1;
        sio_o = ~sio_o;
        // idle gap lets the core see deselect
        #200;
    endtask : frame
endmodule : fss_host_model

`default_nettype wire

//--- fss_lock_status.sv
// Contract
// - read of the status byte is accepted at any time, even mid operation
// - after the read opcode the byte repeats on the output until deselect
// - opcode phase is 8 single-line clocks or 2 quad clocks by mode
// - single-line mode ignores the three upper data lines
// - bit 7 is the scheme selector, one-time bit, default 0
// - bit 6 sets on erase failure, clears on next good erase
// - bit 5 sets on program failure, clears on next good program
// - bit 3 shows erase paused, clears on resume, default 0
// - bit 2 shows program paused, clears on resume, default 0
// - bit 0 shows factory lock of the one-time area
// - bit 1 set once by write command, then one-time area is frozen
// - in one-time-area mode the main array is refused
// - exactly one protection scheme active, chosen by the selector
// - the protection select command sets the selector to 1
// - selector never returns from 1 to 0
// - block mode protects by the four block protect bits
// - status write needs deselect on a byte boundary, else ignored
// - sector mode disables the block protect bits
`timescale 1ns/1ps
`default_nettype none
`include "fss_consts.svh"

module fss_lock_status (
    input wire logic ref_clk_i,
    input wire logic nrst_i,
    input wire logic lnk_sclk_i,
    input wire logic cs_n_i,
    input wire logic [3:0] sio_i,
    output logic [3:0] sio_o,
    output logic [3:0] sio_oe_o,
    input wire logic quad_command_mode_i,
    input wire logic otp_area_mode_i,
    input wire logic [3:0] block_protect_field_i,
    input wire fss_pkg::fss_evt_t evt_i,
    input wire fss_pkg::fss_nv_t nv_i,
    output logic [7:0] lock_and_fail_status_o,
    output fss_pkg::fss_prot_t prot_o,
    output logic write_unlock_latch_o,
    output logic nv_lockdown_prog_o,
    output logic nv_scheme_prog_o
);
    import fss_pkg::*;

    function automatic fss_cmd_t cmd_decode(input logic [7:0] opc);
        fss_cmd_t c;
        c = FSS_CMD_NONE;
        unique case (opc)
            `FSS_OPC_READ_LOCK: c = FSS_CMD_READ_LOCK;
            `FSS_OPC_WRITE_LOCK: c = FSS_CMD_WRITE_LOCK;
            `FSS_OPC_WRITE_UNLOCK: c = FSS_CMD_WRITE_UNLOCK;
            `FSS_OPC_PROTECT_SEL: c = FSS_CMD_PROTECT_SEL;
            default: c = FSS_CMD_NONE;
        endcase
        return c;
    endfunction : cmd_decode

    function automatic logic [3:0] cmd_clks(input logic quad);
        return quad ? `FSS_QUAD_CMD_CLKS : `FSS_SPI_CMD_CLKS;
    endfunction : cmd_clks

    function automatic logic [7:0] status_byte(input fss_core_t s);
        logic [7:0] b;
        b = `FSS_RST_BYTE;
        b[`FSS_POS_SCHEME] = s.scheme;
        b[`FSS_POS_ERASE_FAIL] = s.erase_fail;
        b[`FSS_POS_PROG_FAIL] = s.prog_fail;
        b[`FSS_POS_RSVD] = `FSS_RST_RSVD;
        b[`FSS_POS_ERASE_PAUSED] = s.erase_paused;
        b[`FSS_POS_PROG_PAUSED] = s.prog_paused;
        b[`FSS_POS_LOCKDOWN] = s.lockdown;
        b[`FSS_POS_FACTORY] = s.factory;
        return b;
    endfunction : status_byte

    // link side, clocked by the serial clock
    fss_lk_cmd_t lk_cmd_r;
    fss_lk_cmd_t lk_cmd_nxt;
    fss_lk_out_t lk_out_r;
    fss_lk_out_t lk_out_nxt;
    fss_core_t core_r;
    fss_core_t core_nxt;
    logic frame_rst;
    logic cs_n_s;

    // deselect or reset clears the link drivers without a clock edge
    assign frame_rst = cs_n_i | ~nrst_i;

    always_comb begin
        logic [7:0] opc_n;
        logic [3:0] cnt_prev;
        logic quad;
        logic done;
        opc_n = '0;
        cnt_prev = '0;
        quad = core_r.quad_cfg;
        done = 1'b0;
        lk_cmd_nxt = lk_cmd_r;
        lk_out_nxt = lk_out_r;
        lk_out_nxt.in_frame = 1'b1;
        cnt_prev = lk_out_r.in_frame ? lk_cmd_r.cnt : 4'h0;
        if (quad) begin
            opc_n = {lk_cmd_r.opc[3:0], sio_i};
        end else begin
            opc_n = {lk_cmd_r.opc[6:0], sio_i[0]};
        end
        if (cnt_prev < cmd_clks(quad)) begin
            lk_cmd_nxt.opc = opc_n;
        end
        if (cnt_prev != `FSS_CNT_MAX) begin
            lk_cmd_nxt.cnt = cnt_prev + 4'h1;
        end
        done = (cnt_prev + 4'h1) == cmd_clks(quad);
        if (done && cmd_decode(opc_n) == FSS_CMD_READ_LOCK) begin
            // the byte was frozen in the shadow while deselected
            lk_out_nxt.rd_act = 1'b1;
            if (quad) begin
                lk_out_nxt.sio = core_r.shadow[7:4];
                lk_out_nxt.sh = {core_r.shadow[3:0], core_r.shadow[7:4]};
                lk_out_nxt.sio_oe = `FSS_OE_QUAD;
            end else begin
                lk_out_nxt.sio = {2'h0, core_r.shadow[7], 1'b0};
                lk_out_nxt.sh = {core_r.shadow[6:0], core_r.shadow[7]};
                lk_out_nxt.sio_oe = `FSS_OE_SPI;
            end
        end else if (lk_out_r.rd_act) begin
            // rotating shift register repeats the byte endlessly
            if (quad) begin
                lk_out_nxt.sio = lk_out_r.sh[7:4];
                lk_out_nxt.sh = {lk_out_r.sh[3:0], lk_out_r.sh[7:4]};
            end else begin
                lk_out_nxt.sio = {2'h0, lk_out_r.sh[7], 1'b0};
                lk_out_nxt.sh = {lk_out_r.sh[6:0], lk_out_r.sh[7]};
            end
        end
    end

    always_ff @(posedge lnk_sclk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            lk_cmd_r <= '0;
        end else begin
            lk_cmd_r <= lk_cmd_nxt;
        end
    end

    always_ff @(posedge lnk_sclk_i or posedge frame_rst) begin
        if (frame_rst) begin
            lk_out_r <= '0;
        end else begin
            lk_out_r <= lk_out_nxt;
        end
    end

    assign sio_o = lk_out_r.sio;
    assign sio_oe_o = lk_out_r.sio_oe;

    // core side, clocked by the reference clock
    fss_sync2 #(
        .W(1),
        .RST_VAL(1'b1)
    ) u_cs_sync (
        .clk_i(ref_clk_i),
        .nrst_i(nrst_i),
        .d_i(cs_n_i),
        .q_o(cs_n_s)
    );

    always_comb begin
        logic frame_end;
        logic exact;
        fss_cmd_t cmd;
        frame_end = 1'b0;
        exact = 1'b0;
        cmd = FSS_CMD_NONE;
        core_nxt = core_r;
        core_nxt.cs_prev = cs_n_s;
        core_nxt.nv_lock_prog = 1'b0;
        core_nxt.nv_scheme_prog = 1'b0;

        if (!core_r.loaded) begin
            // one-time bits are taken from storage once after reset
            core_nxt.loaded = 1'b1;
            core_nxt.scheme = nv_i.scheme;
            core_nxt.lockdown = nv_i.lockdown;
            core_nxt.factory = nv_i.factory;
        end

        // result flags follow the last finished operation
        if (evt_i.erase_done) begin
            core_nxt.erase_fail = evt_i.erase_err;
        end
        if (evt_i.prog_done) begin
            core_nxt.prog_fail = evt_i.prog_err;
        end
        // pause flags: a set in the clearing cycle wins
        if (evt_i.erase_resume) begin
            core_nxt.erase_paused = 1'b0;
        end
        if (evt_i.erase_susp) begin
            core_nxt.erase_paused = 1'b1;
        end
        if (evt_i.prog_resume) begin
            core_nxt.prog_paused = 1'b0;
        end
        if (evt_i.prog_susp) begin
            core_nxt.prog_paused = 1'b1;
        end

        // link words are quiet here: the serial clock stops at deselect
        frame_end = cs_n_s && !core_r.cs_prev;
        exact = lk_cmd_r.cnt == cmd_clks(core_r.quad_cfg);
        cmd = cmd_decode(lk_cmd_r.opc);
        if (frame_end && exact && core_r.loaded) begin
            unique case (cmd)
                FSS_CMD_WRITE_UNLOCK: begin
                    core_nxt.unlock_latch = 1'b1;
                end
                FSS_CMD_WRITE_LOCK: begin
                    if (core_r.unlock_latch) begin
                        core_nxt.unlock_latch = 1'b0;
                        if (!core_r.lockdown) begin
                            core_nxt.lockdown = 1'b1;
                            core_nxt.nv_lock_prog = 1'b1;
                        end
                    end
                end
                FSS_CMD_PROTECT_SEL: begin
                    if (core_r.unlock_latch) begin
                        core_nxt.unlock_latch = 1'b0;
                        if (!core_r.scheme) begin
                            core_nxt.scheme = 1'b1;
                            core_nxt.nv_scheme_prog = 1'b1;
                        end
                    end
                end
                FSS_CMD_READ_LOCK, FSS_CMD_NONE: begin
                end
            endcase
        end
        // the selector only ever rises
        core_nxt.scheme = core_nxt.scheme | core_r.scheme;
        core_nxt.lockdown = core_nxt.lockdown | core_r.lockdown;

        // freeze what the link reads while a frame may be running
        if (cs_n_s) begin
            core_nxt.shadow = status_byte(core_nxt);
            core_nxt.quad_cfg = quad_command_mode_i;
        end

        core_nxt.stat = status_byte(core_nxt);
        core_nxt.prot.bp_mode = !core_nxt.scheme;
        core_nxt.prot.sector_mode = core_nxt.scheme;
        if (core_nxt.scheme) begin
            core_nxt.prot.bp_eff = 4'h0;
        end else begin
            core_nxt.prot.bp_eff = block_protect_field_i;
        end
        core_nxt.prot.array_ok = !otp_area_mode_i;
        core_nxt.prot.otp_wr_ok = !core_nxt.lockdown;
    end

    always_ff @(posedge ref_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            // volatile flags start clear
            core_r <= '0;
            core_r.cs_prev <= 1'b1;
            core_r.prot.bp_mode <= 1'b1;
            core_r.prot.array_ok <= 1'b1;
            core_r.prot.otp_wr_ok <= 1'b1;
        end else begin
            core_r <= core_nxt;
        end
    end

    assign lock_and_fail_status_o = core_r.stat;
    assign prot_o = core_r.prot;
    assign write_unlock_latch_o = core_r.unlock_latch;
    assign nv_lockdown_prog_o = core_r.nv_lock_prog;
    assign nv_scheme_prog_o = core_r.nv_scheme_prog;

endmodule : fss_lock_status

`default_nettype wire

//--- fss_lock_status_bench.sv
`timescale 1ns/1ps
`default_nettype none
`include "fss_consts.svh"

`define FSS_CHK(nm, e, s) begin \
    total_checks++; \
    if ((s) !== (e)) begin \
        n_errors++; \
        $display("Error %s expected %h seen %h", nm, e, s); \
    end \
end

module fss_lock_status_bench;
    import fss_pkg::*;
    logic ref_clk = 1'h0, nrst = 1'h0, sclk, cs_n, quad_mode, otp_mode;
    logic unlock_latch, lk_pulse, sc_pulse;
    logic [3:0] host_sio, dut_sio, dut_oe, sio_w, bp_field;
    logic [7:0] status;
    logic [15:0] rd;
    fss_evt_t evt;
    fss_nv_t nv;
    fss_prot_t prot;
    int n_errors = 0, total_checks = 0;
    int n_lk_pulse = 0, n_sc_pulse = 0;
    // rows: event pulse, quad read, expected byte
    logic [16:0] rows [10] = '{
        {8'hc0, 1'h0, 8'h41}, {8'h30, 1'h1, 8'h61}, {8'h08, 1'h0, 8'h69},
        {8'h02, 1'h1, 8'h6d}, {8'h04, 1'h0, 8'h65}, {8'h01, 1'h1, 8'h61},
        {8'h80, 1'h0, 8'h21}, {8'h20, 1'h1, 8'h01}, {8'h0c, 1'h0, 8'h09},
        {8'h03, 1'h1, 8'h0d}};

    always #20 ref_clk = ~ref_clk;
    assign sio_w = (dut_oe & dut_sio) | (~dut_oe & host_sio);

    // store pulses are counted away from the edge that launches them
    always @(negedge ref_clk) begin
        if (lk_pulse === 1'h1) begin
            n_lk_pulse++;
        end
        if (sc_pulse === 1'h1) begin
            n_sc_pulse++;
        end
    end

    fss_host_model host (.sclk_o(sclk), .cs_n_o(cs_n), .sio_o(host_sio),
        .sio_i(sio_w));
    fss_lock_status dut (.ref_clk_i(ref_clk), .nrst_i(nrst),
        .lnk_sclk_i(sclk), .cs_n_i(cs_n), .sio_i(sio_w), .sio_o(dut_sio),
        .sio_oe_o(dut_oe), .quad_command_mode_i(quad_mode),
        .otp_area_mode_i(otp_mode), .block_protect_field_i(bp_field),
        .evt_i(evt), .nv_i(nv), .lock_and_fail_status_o(status),
        .prot_o(prot), .write_unlock_latch_o(unlock_latch),
        .nv_lockdown_prog_o(lk_pulse), .nv_scheme_prog_o(sc_pulse));

    task automatic print_verdict();
        $display("checks %0d errors %0d", total_checks, n_errors);
        if (n_errors == 0 && total_checks > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask : print_verdict

    task automatic lnk(input logic [7:0] op, input logic quad, input int n);
        @(posedge ref_clk) #2 quad_mode = quad;
        repeat (4) @(posedge ref_clk);
        host.frame(op, quad, n,
            op == `FSS_OPC_READ_LOCK ? (quad ? 4 : 16) : 0, rd);
        repeat (2) @(posedge ref_clk);
    endtask : lnk

    initial begin
        quad_mode = 1'h0;
        otp_mode = 1'h0;
        bp_field = 4'ha;
        evt = '0;
        nv = 3'h1;
        repeat (20) @(posedge ref_clk);
        #2 nrst = 1'h1;
        repeat (6) @(posedge ref_clk);
        `FSS_CHK("reset byte", 8'h01, status);
        `FSS_CHK("bp follow", 4'ha, prot.bp_eff);
        @(posedge ref_clk) #2 bp_field = 4'h5;
        repeat (2) @(posedge ref_clk);
        `FSS_CHK("bp change", 4'h5, prot.bp_eff);
        for (int i = 0; i < 10; i++) begin
            @(posedge ref_clk) #2 evt = fss_evt_t'(rows[i][16:9]);
            @(posedge ref_clk) #2 evt = '0;
            repeat (3) @(posedge ref_clk);
            `FSS_CHK("status", rows[i][7:0], status);
            lnk(`FSS_OPC_READ_LOCK, rows[i][8], rows[i][8] ? 2 : 8);
            `FSS_CHK("read", rows[i][7:0], rd[15:8]);
            `FSS_CHK("read again", rows[i][7:0], rd[7:0]);
        end
        lnk(`FSS_OPC_WRITE_LOCK, 1'h0, 8);
        `FSS_CHK("lock no unlock", 1'h0, status[1]);
        lnk(`FSS_OPC_WRITE_UNLOCK, 1'h0, 8);
        `FSS_CHK("unlock latch", 1'h1, unlock_latch);
        lnk(`FSS_OPC_WRITE_LOCK, 1'h0, 9);
        `FSS_CHK("ragged lock", 8'h0d, status);
        `FSS_CHK("ragged store", 0, n_lk_pulse);
        lnk(`FSS_OPC_WRITE_LOCK, 1'h0, 8);
        `FSS_CHK("lockdown", 8'h0f, status);
        `FSS_CHK("lock store", 1, n_lk_pulse);
        `FSS_CHK("otp frozen", 1'h0, prot.otp_wr_ok);
        `FSS_CHK("latch spent", 1'h0, unlock_latch);
        lnk(`FSS_OPC_PROTECT_SEL, 1'h1, 2);
        `FSS_CHK("select refused", 1'h1, prot.bp_mode);
        `FSS_CHK("refused store", 0, n_sc_pulse);
        lnk(`FSS_OPC_WRITE_UNLOCK, 1'h1, 2);
        lnk(`FSS_OPC_PROTECT_SEL, 1'h1, 2);
        `FSS_CHK("select", 8'h8f, status);
        `FSS_CHK("scheme store", 1, n_sc_pulse);
        `FSS_CHK("sector mode", 1'h1, prot.sector_mode);
        `FSS_CHK("bp off", 4'h0, prot.bp_eff);
        @(posedge ref_clk) #2 otp_mode = 1'h1;
        repeat (2) @(posedge ref_clk);
        `FSS_CHK("array closed", 1'h0, prot.array_ok);
        @(posedge ref_clk) #2;
        nrst = 1'h0;
        nv = 3'h4;
        otp_mode = 1'h0;
        repeat (3) @(posedge ref_clk);
        `FSS_CHK("in reset", 8'h00, status);
        #2 nrst = 1'h1;
        repeat (4) @(posedge ref_clk);
        `FSS_CHK("scheme loaded", 8'h80, status);
        print_verdict();
    end
endmodule : fss_lock_status_bench

bind fss_lock_status fss_lock_status_props u_props (
    .ref_clk_i(ref_clk_i), .nrst_i(nrst_i), .cs_n_i(cs_n_i),
    .sio_oe_o(sio_oe_o), .otp_area_mode_i(otp_area_mode_i),
    .block_protect_field_i(block_protect_field_i), .evt_i(evt_i),
    .lock_and_fail_status_o(lock_and_fail_status_o), .prot_o(prot_o),
    .write_unlock_latch_o(write_unlock_latch_o),
    .nv_lockdown_prog_o(nv_lockdown_prog_o),
    .nv_scheme_prog_o(nv_scheme_prog_o));

`default_nettype wire

//--- fss_lock_status_properties.sv
`timescale 1ns/1ps
`default_nettype none

module fss_lock_status_props (
    input wire logic ref_clk_i,
    input wire logic nrst_i,
    input wire logic cs_n_i,
    input wire logic [3:0] sio_oe_o,
    input wire logic otp_area_mode_i,
    input wire logic [3:0] block_protect_field_i,
    input wire fss_pkg::fss_evt_t evt_i,
    input wire logic [7:0] lock_and_fail_status_o,
    input wire fss_pkg::fss_prot_t prot_o,
    input wire logic write_unlock_latch_o,
    input wire logic nv_lockdown_prog_o,
    input wire logic nv_scheme_prog_o
);
    import fss_pkg::*;
    default clocking cb @(posedge ref_clk_i); endclocking
    default disable iff (!nrst_i);

    // a one-time bit is stored only after an unlock, and the latch is spent
    sequence s_granted(logic pulse, logic bit_v);
        $past(write_unlock_latch_o) && bit_v && !write_unlock_latch_o
            ##1 !pulse;
    endsequence

    property p_rsvd;
        lock_and_fail_status_o[4] == 1'h0;
    endproperty
    a_rsvd: assert property (p_rsvd)
        else $error("reserved bit set");
    property p_efail_set;
        evt_i.erase_done && evt_i.erase_err
            |-> ##[1:2] lock_and_fail_status_o[6];
    endproperty
    a_efail_set: assert property (p_efail_set)
        else $error("erase fail not set");
    property p_efail_clr;
        evt_i.erase_done && !evt_i.erase_err
            |-> ##[1:2] !lock_and_fail_status_o[6];
    endproperty
    a_efail_clr: assert property (p_efail_clr)
        else $error("erase fail kept");
    property p_pfail_set;
        evt_i.prog_done && evt_i.prog_err
            |-> ##[1:2] lock_and_fail_status_o[5];
    endproperty
    a_pfail_set: assert property (p_pfail_set)
        else $error("prog fail not set");
    property p_pfail_clr;
        evt_i.prog_done && !evt_i.prog_err
            |-> ##[1:2] !lock_and_fail_status_o[5];
    endproperty
    a_pfail_clr: assert property (p_pfail_clr)
        else $error("prog fail kept");
    property p_epause;
        evt_i.erase_susp |-> ##[1:2] lock_and_fail_status_o[3];
    endproperty
    a_epause: assert property (p_epause)
        else $error("erase pause missing");
    property p_ppause;
        evt_i.prog_susp |-> ##[1:2] lock_and_fail_status_o[2];
    endproperty
    a_ppause: assert property (p_ppause)
        else $error("prog pause missing");
    property p_scheme_sticky;
        lock_and_fail_status_o[7] |=> lock_and_fail_status_o[7];
    endproperty
    a_scheme_sticky: assert property (p_scheme_sticky)
        else $error("scheme fell");
    property p_excl;
        (prot_o.bp_mode ^ prot_o.sector_mode)
            && (prot_o.bp_mode || prot_o.bp_eff == 4'h0);
    endproperty
    a_excl: assert property (p_excl)
        else $error("scheme overlap");
    property p_bp_follow;
        $stable(block_protect_field_i) [*3] ##0 prot_o.bp_mode
            |-> prot_o.bp_eff == block_protect_field_i;
    endproperty
    a_bp_follow: assert property (p_bp_follow)
        else $error("bp not followed");
    property p_array;
        otp_area_mode_i |=> !prot_o.array_ok;
    endproperty
    a_array: assert property (p_array)
        else $error("array open in otp mode");
    property p_lock_pulse;
        nv_lockdown_prog_o
            |-> s_granted(nv_lockdown_prog_o, lock_and_fail_status_o[1]);
    endproperty
    a_lock_pulse: assert property (p_lock_pulse)
        else $error("bad lock store");
    property p_scheme_pulse;
        nv_scheme_prog_o
            |-> s_granted(nv_scheme_prog_o, lock_and_fail_status_o[7]);
    endproperty
    a_scheme_pulse: assert property (p_scheme_pulse)
        else $error("bad scheme store");
    property p_sio_off;
        cs_n_i [*2] |-> sio_oe_o == 4'h0;
    endproperty
    a_sio_off: assert property (p_sio_off)
        else $error("driving while idle");
endmodule : fss_lock_status_props

`default_nettype wire

//--- fss_pkg.sv
`include "fss_consts.svh"

package fss_pkg;

    typedef enum logic [2:0] {
        FSS_CMD_NONE = 3'b000,
        FSS_CMD_READ_LOCK = 3'b001,
        FSS_CMD_WRITE_LOCK = 3'b010,
        FSS_CMD_WRITE_UNLOCK = 3'b011,
        FSS_CMD_PROTECT_SEL = 3'b100
    } fss_cmd_t;

    // events from the program and erase engine
    typedef struct packed {
        logic erase_done;
        logic erase_err;
        logic prog_done;
        logic prog_err;
        logic erase_susp;
        logic erase_resume;
        logic prog_susp;
        logic prog_resume;
    } fss_evt_t;

    // non-volatile one-time bits as stored
    typedef struct packed {
        logic scheme;
        logic lockdown;
        logic factory;
    } fss_nv_t;

    // protection steering towards the array
    typedef struct packed {
        logic bp_mode;
        logic sector_mode;
        logic [3:0] bp_eff;
        logic array_ok;
        logic otp_wr_ok;
    } fss_prot_t;

    typedef struct packed {
        logic loaded;
        logic cs_prev;
        logic unlock_latch;
        logic scheme;
        logic lockdown;
        logic factory;
        logic erase_fail;
        logic prog_fail;
        logic erase_paused;
        logic prog_paused;
        logic [7:0] shadow;
        logic quad_cfg;
        logic [7:0] stat;
        fss_prot_t prot;
        logic nv_lock_prog;
        logic nv_scheme_prog;
    } fss_core_t;

    typedef struct packed {
        logic [7:0] opc;
        logic [3:0] cnt;
    } fss_lk_cmd_t;

    typedef struct packed {
        logic in_frame;
        logic rd_act;
        logic [7:0] sh;
        logic [3:0] sio;
        logic [3:0] sio_oe;
    } fss_lk_out_t;

endpackage : fss_pkg

//--- fss_sync2.sv
`timescale 1ns/1ps
`default_nettype none

// two-flop level synchroniser
module fss_sync2 #(
    parameter int W = 1,
    parameter logic [W-1:0] RST_VAL = '0
) (
    input wire logic clk_i,
    input wire logic nrst_i,
    input wire logic [W-1:0] d_i,
    output logic [W-1:0] q_o
);
    logic [2*W-1:0] st_r;
    logic [2*W-1:0] st_nxt;

    always_comb begin
        st_nxt = {st_r[W-1:0], d_i};
    end

    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            st_r <= {RST_VAL, RST_VAL};
        end else begin
            st_r <= st_nxt;
        end
    end

    assign q_o = st_r[2*W-1:W];

endmodule : fss_sync2

`default_nettype wire
